// *** rtl/io_processor_datapath.sv ***
`timescale 1ns/1ps
`include "iop_cfg.svh"
module io_processor_datapath (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic INIT_I,
    input wire logic WAIT_I,
    input wire logic [15:0] INSTR_I,
    input wire logic [2:0] SRC_SEL_I,
    input wire logic [4:0] ALU_FUNC_I,
    input wire logic PASS_B_I,
    input wire logic IS_MOVE_I,
    input wire logic IS_BRANCH_I,
    input wire logic CARRY_CLOCK_ENABLE_I,
    input wire logic PORT_WRITE_I,
    input wire logic [2:0] READBACK_SEL_I,
    input wire logic [3:0] DEST_SEL_I,
    input wire logic DP_LOAD_LO_I,
    input wire logic DP_LOAD_HI_I,
    input wire logic DP_INC_I,
    input wire logic [7:0] BRANCH_CONDS_I,
    input wire logic LU_PRESENT_I,
    input wire logic [7:0] LINE_UNIT_INPUT_I,
    input wire logic CPU_RAM_WRITE_CYCLE_I,
    input wire logic DMA_BUS_OWNER_N_I,
    input wire logic DMA_DIRECTION_OUT_I,
    input wire logic BUS_WRITE_SELECT_N_I,
    input wire logic DMA_LOAD_I,
    input wire logic HOST_LOAD_I,
    input wire logic LOW_BYTE_WRITE_N_I,
    input wire logic HIGH_BYTE_WRITE_N_I,
    input wire logic [2:0] HOST_ADDR_I,
    input wire logic [15:0] HOST_DATA_I,
    output logic [15:0] RAM_PORT_A_O,
    output logic [15:0] RAM_PORT_B_O,
    output logic [7:0] PORT_OUT_O,
    output logic [2:0] LU_ADDR_O,
    output logic [13:0] PC_O,
    output logic [11:0] DATA_POINTER_O,
    output logic [1:0] PHASE_O,
    output logic CARRY_O,
    output logic ALL_ONES_O,
    output logic [7:0] DMA_CTRL_O,
    output logic [7:0] MISC_O
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    iop_pkg::state_t s_q, s_d;
    logic [7:0] scratchpad_store [16];
    logic [7:0] data_mem [4096];
    logic [15:0] shared_port_ram [8];
    logic lu_ff1_q, lu_ff2_q;
    logic [7:0] lu_data1_q, lu_data2_q;
    logic wait1_q, wait2_q;
    logic [3:0] sp_addr;
    logic [7:0] op_a, op_b, alu_res, line_unit_input;
    logic alu_cout, ram_we, branch_cond;
    logic [8:0] sum;
    logic [2:0] ram_a_addr, ram_b_addr;
    logic [15:0] ram_a_data;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge MCLK_I)
    begin
        lu_ff1_q <= LU_PRESENT_I;
        lu_ff2_q <= lu_ff1_q;
        lu_data1_q <= LINE_UNIT_INPUT_I;
        lu_data2_q <= lu_data1_q;
        wait1_q <= WAIT_I;
        wait2_q <= wait1_q;
    end

    // Floating inputs read as all ones, as a pulled-up bus would.
    assign line_unit_input = lu_ff2_q ? lu_data2_q : `ALL_ONES;
    assign LU_ADDR_O = s_q.instruction_word[2:0];

    // ----------------------------------------
    // Source bus and ALU
    // ----------------------------------------
    assign sp_addr = PORT_WRITE_I ? `SP_OUT_ADDR : s_q.instruction_word[3:0];
    assign op_a = scratchpad_store[sp_addr];

    always_comb
    begin
        if (READBACK_SEL_I[2])
        begin
            case (READBACK_SEL_I[1:0])
                2'h0: op_b = s_q.pc_read[7:0];
                2'h1: op_b = {2'h0, s_q.pc_read[13:8]};
                2'h2: op_b = s_q.dp_read[7:0];
                default: op_b = {4'h0, s_q.dp_read[11:8]};
            endcase
        end
        else
        begin
            case (SRC_SEL_I)
                `SRC_IMM: op_b = s_q.instruction_word[7:0];
                `SRC_LU: op_b = line_unit_input;
                `SRC_MEM: op_b = data_mem[s_q.data_pointer];
                `SRC_BRG: op_b = s_q.branch_shift_register;
                `SRC_RAM_LO: op_b = RAM_PORT_B_O[7:0];
                `SRC_RAM_HI: op_b = RAM_PORT_B_O[15:8];
                `SRC_DMA: op_b = {s_q.dma_ctrl[7], s_q.dp_prev[10], s_q.dp_prev[8],
                                  s_q.dma_ctrl[4:0]};
                default: op_b = s_q.misc;
            endcase
        end
    end

    // Function bit 4 selects logic mode; bit 0 of the low nibble is carry in.
    always_comb
    begin
        sum = 9'h000;
        alu_res = op_b;
        alu_cout = 1'b0;
        if (!PASS_B_I)
        begin
            if (ALU_FUNC_I[4])
            begin
                case (ALU_FUNC_I[3:0])
                    4'h0: alu_res = ~op_a;
                    4'h1: alu_res = ~(op_a | op_b);
                    4'h2: alu_res = ~op_a & op_b;
                    4'h3: alu_res = 8'h00;
                    4'h4: alu_res = ~(op_a & op_b);
                    4'h5: alu_res = ~op_b;
                    4'h6: alu_res = op_a ^ op_b;
                    4'h7: alu_res = op_a & ~op_b;
                    4'h8: alu_res = ~op_a | op_b;
                    4'h9: alu_res = ~(op_a ^ op_b);
                    4'ha: alu_res = op_b;
                    4'hb: alu_res = op_a & op_b;
                    4'hc: alu_res = 8'hff;
                    4'hd: alu_res = op_a | ~op_b;
                    4'he: alu_res = op_a | op_b;
                    default: alu_res = op_a;
                endcase
            end
            else
            begin
                case (ALU_FUNC_I[3:1])
                    3'h0: sum = {1'b0, op_a} + {8'h00, ALU_FUNC_I[0]};
                    3'h1: sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, ALU_FUNC_I[0]};
                    3'h2: sum = {1'b0, op_a} + {1'b0, ~op_b} + {8'h00, ALU_FUNC_I[0]};
                    3'h3: sum = {1'b0, op_a} + {1'b0, op_a} + {8'h00, ALU_FUNC_I[0]};
                    3'h4: sum = {1'b0, op_a} + 9'h0ff + {8'h00, ALU_FUNC_I[0]};
                    3'h5: sum = {1'b0, op_a & op_b} + {1'b0, op_a} + {8'h00, ALU_FUNC_I[0]};
                    3'h6: sum = {1'b0, op_a | op_b} + {1'b0, op_a} + {8'h00, ALU_FUNC_I[0]};
                    default: sum = {1'b0, op_b} + {8'h00, ALU_FUNC_I[0]};
                endcase
                alu_res = sum[7:0];
                alu_cout = sum[8];
            end
        end
    end

    // ----------------------------------------
    // Branch condition
    // ----------------------------------------
    assign branch_cond = IS_BRANCH_I & BRANCH_CONDS_I[s_q.instruction_word[10:8]];

    // ----------------------------------------
    // Shared port RAM
    // ----------------------------------------
    assign ram_we = DMA_LOAD_I | (CPU_RAM_WRITE_CYCLE_I & s_q.phase == iop_pkg::PH_THIRD)
                    | HOST_LOAD_I;
    always_comb
    begin
        if (CPU_RAM_WRITE_CYCLE_I)
        begin
            ram_a_addr = s_q.instruction_word[2:0];
            ram_a_data = {alu_res, alu_res};
        end
        else
        begin
            ram_a_data = HOST_DATA_I;
            if (!DMA_BUS_OWNER_N_I)
                ram_a_addr = {1'b0, DMA_DIRECTION_OUT_I ? `RAM_DMA_OUT : `RAM_DMA_IN};
            else
                ram_a_addr = HOST_ADDR_I;
        end
        if (!BUS_WRITE_SELECT_N_I)
            ram_b_addr = {1'b0, DMA_DIRECTION_OUT_I ? `RAM_DMA_WR : `RAM_DMA_RD};
        else
            ram_b_addr = {s_q.instruction_word[15], s_q.instruction_word[6:5]};
    end

    // Reads blank while writing so no half-written word is seen.
    assign RAM_PORT_A_O = ram_we ? 16'h0000 : shared_port_ram[ram_a_addr];
    assign RAM_PORT_B_O = ram_we ? 16'h0000 : shared_port_ram[ram_b_addr];

    always_ff @(posedge MCLK_I)
    begin
        if (ram_we & !LOW_BYTE_WRITE_N_I)
            shared_port_ram[ram_a_addr][7:0] <= ram_a_data[7:0];
        if (ram_we & !HIGH_BYTE_WRITE_N_I)
            shared_port_ram[ram_a_addr][15:8] <= ram_a_data[15:8];
        if (IS_MOVE_I & s_q.phase == iop_pkg::PH_FOURTH & DEST_SEL_I == 4'h1)
            scratchpad_store[sp_addr] <= ~(~s_q.alu_output_latch);
        if (IS_MOVE_I & s_q.phase == iop_pkg::PH_FOURTH & DEST_SEL_I == 4'h2)
            data_mem[s_q.data_pointer] <= s_q.alu_output_latch;
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb
    begin
        s_d = s_q;
        case (s_q.phase)
            iop_pkg::PH_FIRST:
            begin
                s_d.phase = iop_pkg::PH_SECOND;
                s_d.instruction_word = INSTR_I;
                s_d.dp_prev = s_q.data_pointer;
            end
            iop_pkg::PH_SECOND:
            begin
                if (!wait2_q)
                begin
                    s_d.phase = iop_pkg::PH_THIRD;
                    s_d.branch_taken = branch_cond;
                    if (!branch_cond)
                        s_d.pc = s_q.pc + 14'h0001;
                end
            end
            iop_pkg::PH_THIRD:
            begin
                s_d.phase = iop_pkg::PH_FOURTH;
                s_d.alu_output_latch = alu_res;
                s_d.pc_read = s_q.pc;
                s_d.dp_read = s_q.dp_prev;
                if (IS_MOVE_I & CARRY_CLOCK_ENABLE_I)
                    s_d.carry = alu_cout;
                if (IS_MOVE_I)
                    s_d.all_ones_flag = (alu_res == `ALL_ONES);
                if (s_q.branch_taken)
                begin
                    s_d.pc[7:0] = alu_res;
                    if (s_q.instruction_word[10:8] == `BR_COND_PAGE)
                        s_d.pc[13:8] = s_q.branch_page_register;
                    else
                        s_d.pc[9:8] = s_q.instruction_word[12:11];
                end
            end
            iop_pkg::PH_FOURTH:
            begin
                s_d.phase = iop_pkg::PH_FIRST;
                if (IS_MOVE_I)
                begin
                    case (DEST_SEL_I)
                        4'h3: s_d.branch_shift_register = s_q.alu_output_latch;
                        4'h4: s_d.dma_ctrl = s_q.alu_output_latch;
                        4'h5: s_d.misc = s_q.alu_output_latch;
                        4'h6: s_d.branch_page_register = s_q.alu_output_latch[5:0];
                        4'h7: s_d.port_out = s_q.alu_output_latch;
                        default: s_d.port_out = s_q.port_out;
                    endcase
                    if (DP_LOAD_LO_I)
                        s_d.data_pointer[7:0] = s_q.alu_output_latch;
                    else if (DP_LOAD_HI_I)
                        s_d.data_pointer[11:8] = s_q.alu_output_latch[3:0];
                    else if (DP_INC_I)
                        s_d.data_pointer = s_q.data_pointer + 12'h001;
                end
            end
            default: s_d.phase = iop_pkg::PH_FIRST;
        endcase
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RESETN_I | INIT_I)
        begin
            s_q <= '0;
            s_q.pc <= `PC_RESET;
            s_q.data_pointer <= `DP_RESET;
        end
        else
            s_q <= s_d;
    end

    assign PORT_OUT_O = s_q.port_out;
    assign PC_O = s_q.pc;
    assign DATA_POINTER_O = s_q.data_pointer;
    assign PHASE_O = s_q.phase;
    assign CARRY_O = s_q.carry;
    assign ALL_ONES_O = s_q.all_ones_flag;
    assign DMA_CTRL_O = s_q.dma_ctrl;
    assign MISC_O = s_q.misc;
endmodule : io_processor_datapath

// *** shared/iop_cfg.svh ***
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH
`define SRC_IMM 3'h0
`define SRC_LU 3'h1
`define SRC_MEM 3'h2
`define SRC_BRG 3'h3
`define SRC_RAM_LO 3'h4
`define SRC_RAM_HI 3'h5
`define SRC_DMA 3'h6
`define SRC_MISC 3'h7
`define ALL_ONES 8'hff
`define DP_RESET 12'h000
`define PC_RESET 14'h0000
`define PHASE_NS 60
`define CLK_NS 40
`define SP_OUT_ADDR 4'h0
`define RAM_DMA_IN 2'h0
`define RAM_DMA_OUT 2'h1
`define RAM_DMA_RD 2'h2
`define RAM_DMA_WR 2'h3
`define BR_COND_PAGE 3'h0
`endif

// *** shared/iop_pkg.sv ***
package iop_pkg;
    typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [15:0] instruction_word;
        logic [7:0] alu_output_latch;
        logic carry;
        logic all_ones_flag;
        logic [11:0] data_pointer;
        logic [11:0] dp_prev;
        logic [13:0] pc;
        logic [13:0] pc_read;
        logic [11:0] dp_read;
        logic [7:0] branch_shift_register;
        logic [5:0] branch_page_register;
        logic [7:0] dma_ctrl;
        logic [7:0] misc;
        logic [7:0] port_out;
        logic branch_taken;
    } state_t;
endpackage : iop_pkg

// *** sim/io_processor_datapath_assertions.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Timing checks on the datapath outputs
// ----------------------------------------
module io_processor_datapath_checker (
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic INIT_I,
    input wire logic IS_MOVE_I,
    input wire logic IS_BRANCH_I,
    input wire logic CARRY_CLOCK_ENABLE_I,
    input wire logic [1:0] PHASE_O,
    input wire logic [13:0] PC_O,
    input wire logic [11:0] DATA_POINTER_O,
    input wire logic [7:0] PORT_OUT_O,
    input wire logic CARRY_O,
    input wire logic ALL_ONES_O
);
    // A clear on the previous edge explains any jump in the registered outputs.
    logic clr_q;
    always_ff @(posedge MCLK_I)
        clr_q <= !RESETN_I || INIT_I;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    first_phase_a: assert property (PHASE_O == 2'h0 && !INIT_I |=> PHASE_O == 2'h1)
        else $error("first phase did not advance");
    second_hold_a: assert property (PHASE_O == 2'h1 && !INIT_I |=> PHASE_O inside {2'h1, 2'h2})
        else $error("second phase left wrongly");
    pc_step_a: assert property (PHASE_O == 2'h2 && $past(PHASE_O) == 2'h1 && !$past(IS_BRANCH_I)
        |-> PC_O == $past(PC_O) + 14'h1) else $error("counter did not step");
    pc_window_a: assert property ($changed(PC_O) |-> clr_q || $past(PHASE_O) inside {2'h1, 2'h2})
        else $error("counter moved outside its phases");
    carry_window_a: assert property ($changed(CARRY_O) |-> clr_q || ($past(PHASE_O) == 2'h2
        && $past(IS_MOVE_I) && $past(CARRY_CLOCK_ENABLE_I))) else $error("carry moved wrongly");
    ones_window_a: assert property ($changed(ALL_ONES_O) |-> clr_q
        || ($past(PHASE_O) == 2'h2 && $past(IS_MOVE_I))) else $error("ones flag moved wrongly");
    port_window_a: assert property ($changed(PORT_OUT_O) |-> clr_q || $past(PHASE_O) == 2'h3)
        else $error("port output moved outside fourth phase");
    init_clear_a: assert property (INIT_I |=> PC_O == 14'h0 && DATA_POINTER_O == 12'h0
        && !CARRY_O && !ALL_ONES_O) else $error("clear left state behind");
    cover property (PHASE_O == 2'h1 ##1 PHASE_O == 2'h1);
    cover property ($rose(ALL_ONES_O));
    cover property (INIT_I ##1 PHASE_O == 2'h0);
endmodule : io_processor_datapath_checker
bind io_processor_datapath io_processor_datapath_checker checks (.*);

// *** sim/io_processor_datapath_tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module io_processor_datapath_tb;
    typedef struct packed {
        logic [15:0] ins;
        logic [2:0] src;
        logic [3:0] dst;
        logic [2:0] dp;
        logic br;
        logic [1:0] sel;
        logic [7:0] exp;
    } row_t;
    logic MCLK_I, RESETN_I, INIT_I, WAIT_I, PASS_B_I, IS_MOVE_I, IS_BRANCH_I, PORT_WRITE_I;
    logic CARRY_CLOCK_ENABLE_I, DP_LOAD_LO_I, DP_LOAD_HI_I, DP_INC_I, LU_PRESENT_I, DMA_LOAD_I;
    logic CPU_RAM_WRITE_CYCLE_I, DMA_BUS_OWNER_N_I, DMA_DIRECTION_OUT_I, BUS_WRITE_SELECT_N_I;
    logic HOST_LOAD_I, LOW_BYTE_WRITE_N_I, HIGH_BYTE_WRITE_N_I, CARRY_O, ALL_ONES_O, h_req;
    logic [15:0] INSTR_I, HOST_DATA_I, RAM_PORT_A_O, RAM_PORT_B_O, h_data;
    logic [2:0] SRC_SEL_I, READBACK_SEL_I, HOST_ADDR_I, LU_ADDR_O, h_addr;
    logic [7:0] BRANCH_CONDS_I, LINE_UNIT_INPUT_I, PORT_OUT_O, DMA_CTRL_O, MISC_O;
    logic [4:0] ALU_FUNC_I;
    logic [3:0] DEST_SEL_I;
    logic [13:0] PC_O;
    logic [11:0] DATA_POINTER_O;
    logic [1:0] PHASE_O, h_be;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    row_t rows [12];

    io_processor_datapath DUT (.*);
    ram_host_model host (.clk_i(MCLK_I), .req_i(h_req), .addr_i(h_addr), .data_i(h_data),
        .be_i(h_be), .load_o(HOST_LOAD_I), .addr_o(HOST_ADDR_I), .data_o(HOST_DATA_I),
        .low_n_o(LOW_BYTE_WRITE_N_I), .high_n_o(HIGH_BYTE_WRITE_N_I));

    initial
    begin
        MCLK_I = 1'b0;
        forever #20 MCLK_I = ~MCLK_I;
    end

    task automatic complete_run();
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // The whole run needs under 150 cycles, so this ceiling only catches a hang.
    always @(posedge MCLK_I)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The core can stall in the second phase, so wait up to 8 falling edges for the first phase before a new word goes in.
    task automatic start(input row_t r);
        for (int k = 0; k < 8 && PHASE_O !== 2'h0; k++)
            @(negedge MCLK_I);
        {INSTR_I, SRC_SEL_I, DEST_SEL_I, ALU_FUNC_I} = {r.ins, r.src, r.dst, r.ins[8:4]};
        {DP_INC_I, DP_LOAD_HI_I, DP_LOAD_LO_I, IS_BRANCH_I, IS_MOVE_I} = {r.dp, r.br, !r.br};
        {PORT_WRITE_I, CARRY_CLOCK_ENABLE_I} = {r.dst == 4'h7, r.ins[4]};
    endtask : start

    task automatic exec(input row_t r);
        start(r);
        repeat (4) @(negedge MCLK_I);
    endtask : exec

    task automatic run_row(input row_t r);
        exec(r);
        case (r.sel)
            2'h0: chk(PORT_OUT_O, r.exp);
            2'h1: chk(DMA_CTRL_O, r.exp);
            2'h2: chk(MISC_O, r.exp);
            default: chk(DATA_POINTER_O[7:0], r.exp);
        endcase
    endtask : run_row

    task automatic host_wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be,
        input logic [15:0] exp);
        @(negedge MCLK_I);
        {h_req, h_addr, h_data, h_be} = {1'b1, a, d, be};
        @(negedge MCLK_I);
        h_req = 1'b0;
        chk(RAM_PORT_A_O, 0);
        @(negedge MCLK_I);
        chk(RAM_PORT_A_O, exp);
    endtask : host_wr

    initial
    begin
        {INIT_I, WAIT_I, IS_MOVE_I, IS_BRANCH_I, CARRY_CLOCK_ENABLE_I, PORT_WRITE_I} = '0;
        {DP_LOAD_LO_I, DP_LOAD_HI_I, DP_INC_I, LU_PRESENT_I, CPU_RAM_WRITE_CYCLE_I} = '0;
        {DMA_LOAD_I, DMA_DIRECTION_OUT_I, h_req, RESETN_I} = '0;
        {DMA_BUS_OWNER_N_I, BUS_WRITE_SELECT_N_I, PASS_B_I} = 3'h7;
        {INSTR_I, SRC_SEL_I, READBACK_SEL_I, ALU_FUNC_I, DEST_SEL_I} = '0;
        {BRANCH_CONDS_I, LINE_UNIT_INPUT_I, h_addr, h_data, h_be} = '0;
        rows = '{'{16'h005a, 3'h0, 4'h7, 3'h0, 1'b0, 2'h0, 8'h5a},
            '{16'h003c, 3'h0, 4'h4, 3'h0, 1'b0, 2'h1, 8'h3c},
            '{16'h00c3, 3'h0, 4'h5, 3'h0, 1'b0, 2'h2, 8'hc3},
            '{16'h0000, 3'h6, 4'h7, 3'h0, 1'b0, 2'h0, 8'h1c},
            '{16'h0000, 3'h7, 4'h7, 3'h0, 1'b0, 2'h0, 8'hc3},
            '{16'h0077, 3'h0, 4'h2, 3'h0, 1'b0, 2'h0, 8'hc3},
            '{16'h0000, 3'h2, 4'h7, 3'h0, 1'b0, 2'h0, 8'h77},
            '{16'h0000, 3'h4, 4'h7, 3'h0, 1'b0, 2'h0, 8'h5a},
            '{16'h0000, 3'h5, 4'h7, 3'h0, 1'b0, 2'h0, 8'ha5},
            '{16'h0000, 3'h1, 4'h7, 3'h0, 1'b0, 2'h0, 8'hff},
            '{16'h0034, 3'h0, 4'h0, 3'h1, 1'b0, 2'h3, 8'h34},
            '{16'h0000, 3'h0, 4'h0, 3'h4, 1'b0, 2'h3, 8'h35}};
        repeat (10) @(negedge MCLK_I);
        chk({PC_O, DATA_POINTER_O, PHASE_O, CARRY_O, ALL_ONES_O, PORT_OUT_O}, 0);
        RESETN_I = 1'b1;
        host_wr(3'h0, 16'h0000, 2'h3, 16'h0000);
        host_wr(3'h0, 16'ha5ff, 2'h2, 16'ha500);
        host_wr(3'h0, 16'hff5a, 2'h1, 16'ha55a);
        host_wr(3'h1, 16'hc33c, 2'h3, 16'hc33c);
        host_wr(3'h3, 16'h1234, 2'h3, 16'h1234);
        DMA_BUS_OWNER_N_I = 1'b0;
        @(negedge MCLK_I);
        chk(RAM_PORT_A_O, 16'ha55a);
        DMA_DIRECTION_OUT_I = 1'b1;
        BUS_WRITE_SELECT_N_I = 1'b0;
        @(negedge MCLK_I);
        chk(RAM_PORT_A_O, 16'hc33c);
        chk(RAM_PORT_B_O, 16'h1234);
        DMA_BUS_OWNER_N_I = 1'b1;
        BUS_WRITE_SELECT_N_I = 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        chk(RAM_PORT_B_O, 16'ha55a);
        WAIT_I = 1'b1;
        start('{16'h00ff, 3'h0, 4'h0, 3'h0, 1'b0, 2'h0, 8'h0});
        repeat (6) @(negedge MCLK_I);
        chk(PHASE_O, 2'h1);
        WAIT_I = 1'b0;
        repeat (8) @(negedge MCLK_I);
        chk(ALL_ONES_O, 1'b1);
        {LU_PRESENT_I, LINE_UNIT_INPUT_I} = {1'b1, 8'h96};
        run_row('{16'h0005, 3'h1, 4'h7, 3'h0, 1'b0, 2'h0, 8'h96});
        chk(LU_ADDR_O, 3'h5);
        exec('{16'h0080, 3'h0, 4'h1, 3'h0, 1'b0, 2'h0, 8'h0});
        PASS_B_I = 1'b0;
        run_row('{16'h0030, 3'h7, 4'h7, 3'h0, 1'b0, 2'h0, 8'h44});
        chk(CARRY_O, 1'b1);
        run_row('{16'h0160, 3'h7, 4'h7, 3'h0, 1'b0, 2'h0, 8'h43});
        chk(CARRY_O, 1'b1);
        PASS_B_I = 1'b1;
        BRANCH_CONDS_I = 8'h02;
        exec('{16'h1940, 3'h0, 4'h0, 3'h0, 1'b1, 2'h0, 8'h0});
        chk(PC_O, 14'h0340);
        BRANCH_CONDS_I = 8'hfd;
        exec('{16'h0140, 3'h0, 4'h0, 3'h0, 1'b1, 2'h0, 8'h0});
        chk(PC_O, 14'h0341);
        exec('{16'h002a, 3'h0, 4'h6, 3'h0, 1'b0, 2'h0, 8'h0});
        BRANCH_CONDS_I = 8'h01;
        exec('{16'h0055, 3'h0, 4'h0, 3'h0, 1'b1, 2'h0, 8'h0});
        chk(PC_O, 14'h2a55);
        INIT_I = 1'b1;
        @(negedge MCLK_I);
        INIT_I = 1'b0;
        chk({PC_O, DATA_POINTER_O, PHASE_O, CARRY_O, ALL_ONES_O, PORT_OUT_O}, 0);
        READBACK_SEL_I = 3'h4;
        run_row('{16'h0000, 3'h0, 4'h7, 3'h0, 1'b0, 2'h0, 8'h00});
        run_row('{16'h0000, 3'h0, 4'h7, 3'h0, 1'b0, 2'h0, 8'h01});
        complete_run();
    end
endmodule : io_processor_datapath_tb

// *** sim/ram_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the shared RAM
// ----------------------------------------
module ram_host_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [2:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic [1:0] be_i,
    output logic load_o,
    output logic [2:0] addr_o,
    output logic [15:0] data_o,
    output logic low_n_o,
    output logic high_n_o
);
    initial
    begin
        {load_o, addr_o, data_o, low_n_o, high_n_o} = {20'h0, 2'h3};
    end
    // A released data bus toggles so that stale data never looks valid.
    always @(posedge clk_i)
    begin
        load_o <= req_i;
        low_n_o <= !(req_i && be_i[0]);
        high_n_o <= !(req_i && be_i[1]);
        addr_o <= req_i ? addr_i : addr_o;
        data_o <= req_i ? data_i : ~data_o;
    end
endmodule : ram_host_model
